// *** dcs_front_end_model.sv ***
// Behavioural model of the discharge front end and comparator
`timescale 1ns/100ps
`default_nettype none
module dcs_front_end_model (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic i_seq_done,
  input wire logic [15:0] i_delay,
  input wire logic [23:0] i_val_even,
  input wire logic [23:0] i_val_odd,
  output logic o_meas_done,
  output logic [23:0] o_meas_value
);
  logic [15:0] wait_cnt;
  logic busy;
  logic odd;
  // ----------------------------------------------------------------
  // Discharge timing
  // ----------------------------------------------------------------
  // discharge then done
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy <= 1'b0;
      odd <= 1'b0;
      wait_cnt <= 16'h0000;
      o_meas_done <= 1'b0;
      o_meas_value <= 24'h5a5a5a;
    end else begin
      o_meas_done <= 1'b0;
      o_meas_value <= ~o_meas_value;
      if (i_seq_done) begin
        odd <= 1'b0;
      end
      if (i_start) begin
        busy <= 1'b1;
        wait_cnt <= i_delay;
      end else if (busy) begin
        if (wait_cnt <= 16'h0001) begin
          busy <= 1'b0;
          o_meas_done <= 1'b1;
          o_meas_value <= odd ? i_val_odd : i_val_even;
          odd <= ~odd;
        end else begin
          wait_cnt <= wait_cnt - 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** dcs_interval_timer.sv ***
// Loadable down counter that steps on a tick and flags zero
`timescale 1ns/100ps
`default_nettype none
module dcs_interval_timer #(
  parameter int W = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire logic i_tick,
  output logic o_expired
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= '0;
    end else if (i_load) begin
      cnt_reg <= i_load_val;
    end else if (i_tick && (cnt_reg != '0)) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign o_expired = (cnt_reg == '0);
endmodule
`default_nettype wire

// *** dcs_map.svh ***
// Register map, field positions and timing constants of the discharge cycle sequencer
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DCS_ADDR_CTRL 12'h000
`define DCS_ADDR_CFG2 12'h004
`define DCS_ADDR_CFG3 12'h008
`define DCS_ADDR_STATUS 12'h00c
`define DCS_ADDR_MASK 12'h010
`define DCS_ADDR_RESULT 12'h014
`define DCS_ADDR_SEQ 12'h018
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCS_CTRL_RUN 0
`define DCS_CFG2_SINGLE 2
`define DCS_CFG2_CYTIME_LO 4
`define DCS_CFG2_CYTIME_HI 13
`define DCS_CFG2_AVG_LO 14
`define DCS_CFG2_AVG_HI 23
`define DCS_CFG3_BRIDGE_LO 0
`define DCS_CFG3_BRIDGE_HI 1
`define DCS_CFG3_ADJ_LO 4
`define DCS_CFG3_ADJ_HI 9
`define DCS_CFG3_STRETCH_LO 12
`define DCS_CFG3_STRETCH_HI 13
`define DCS_CFG3_EXTRA_LO 16
`define DCS_CFG3_EXTRA_HI 19
`define DCS_ST_DONE 0
`define DCS_ST_OVF 1
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DCS_CTRL_RST 32'h0000_0000
`define DCS_CFG2_RST 32'h0000_8500
`define DCS_CFG3_RST 32'h0007_0021
`define DCS_MASK_RST 2'h0
// ----------------------------------------------------------------
// Timing, result range and cycles per sample
// ----------------------------------------------------------------
`define DCS_CLK_PERIOD_NS 8
`define DCS_FAST_STEP_NS 2000
`define DCS_FAST_STEP_CYC ((`DCS_FAST_STEP_NS / `DCS_CLK_PERIOD_NS) - 1)
`define DCS_FIRE_LEAD_CYC 2
`define DCS_FAST_FIRST_CYC (`DCS_FAST_STEP_CYC - `DCS_FIRE_LEAD_CYC)
`define DCS_RES_MAX 32'sh007f_ffff
`define DCS_RES_MIN 32'shff80_0000
`define DCS_CPS_HALF 4'h2
`define DCS_CPS_FULL 4'h4
`define DCS_CPS_QUATTRO 4'h8
`endif

// *** dcs_pkg.sv ***
// Types shared by the discharge cycle sequencer files
package dcs_pkg;
  typedef enum logic [1:0] {
    BRIDGE_HALF = 2'h0,
    BRIDGE_FULL = 2'h1,
    BRIDGE_RSVD = 2'h2,
    BRIDGE_QUATTRO = 2'h3
  } bridge_t;

  typedef enum {ST_IDLE, ST_FIRE, ST_MEAS, ST_GAP, ST_DONE} seq_state_t;

  typedef struct packed {
    logic single;
    logic [9:0] cytime;
    logic [9:0] avg;
  } cfg2_t;

  typedef struct packed {
    bridge_t bridge;
    logic [5:0] adjust;
    logic [1:0] stretch;
    logic [3:0] extra;
  } cfg3_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// *** dcs_sequencer.sv ***
// Discharge cycle sequencer with APB register file
// Behaviour
// - Successive discharges are spaced by a programmable interval covering discharge and recharge
// - Normal mode: interval is cycle field times 2 us from the fast clock
// - Stretched mode: interval counts 100 us ticks of the slow oscillator
// - Stretched mode: field sets the wait between two discharging cycles
// - Normal mode only: overflow flagged when interval expires before the discharge ends
// - Two, four or eight discharges per sample for half, full, quattro
// - One full set of cycles is one sample; one sample minimum
// - Average count samples form one measurement; cycles equal samples times per-sample
// - Extra compensation and fake cycles complete each sequence before the result
// - Result is a 24-bit two's complement word, saturated to its range
// - Bridge field: 0 half, 1 full, 3 quattro grouping
// - Stretched: half bridge pair spaced by stretch setting times 100 us
`timescale 1ns/100ps
`default_nettype none
`include "dcs_map.svh"
module dcs_sequencer
  import dcs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_slow_tick,
  input wire logic i_meas_done,
  input wire logic [23:0] i_meas_value,
  output logic o_discharge_start,
  output logic o_seq_done,
  output logic [23:0] o_bridge_result_word,
  output logic o_irq
);
  // Reset words held as parameters so their fields can be selected
  localparam logic [31:0] ctrl_rst = `DCS_CTRL_RST;
  localparam logic [31:0] cfg2_rst = `DCS_CFG2_RST;
  localparam logic [31:0] cfg3_rst = `DCS_CFG3_RST;
  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  apb_req_t req;
  logic wr_en;
  logic run_reg;
  cfg2_t cfg2_reg;
  cfg3_t cfg3_reg;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic [1:0] status_set;
  logic [23:0] result_reg;
  logic mapped;
  seq_state_t state_reg;

  assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                 paddr: i_paddr, pwdata: i_pwdata};
  assign wr_en = req.psel && req.penable && req.pwrite && mapped;
  assign o_pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    o_prdata = 32'h0000_0000;
    unique case (req.paddr)
      `DCS_ADDR_CTRL: o_prdata[`DCS_CTRL_RUN] = run_reg;
      `DCS_ADDR_CFG2: begin
        o_prdata[`DCS_CFG2_SINGLE] = cfg2_reg.single;
        o_prdata[`DCS_CFG2_CYTIME_HI:`DCS_CFG2_CYTIME_LO] = cfg2_reg.cytime;
        o_prdata[`DCS_CFG2_AVG_HI:`DCS_CFG2_AVG_LO] = cfg2_reg.avg;
      end
      `DCS_ADDR_CFG3: begin
        o_prdata[`DCS_CFG3_BRIDGE_HI:`DCS_CFG3_BRIDGE_LO] = cfg3_reg.bridge;
        o_prdata[`DCS_CFG3_ADJ_HI:`DCS_CFG3_ADJ_LO] = cfg3_reg.adjust;
        o_prdata[`DCS_CFG3_STRETCH_HI:`DCS_CFG3_STRETCH_LO] = cfg3_reg.stretch;
        o_prdata[`DCS_CFG3_EXTRA_HI:`DCS_CFG3_EXTRA_LO] = cfg3_reg.extra;
      end
      `DCS_ADDR_STATUS: o_prdata[1:0] = status_reg;
      `DCS_ADDR_MASK: o_prdata[1:0] = mask_reg;
      `DCS_ADDR_RESULT: o_prdata[23:0] = result_reg;
      `DCS_ADDR_SEQ: o_prdata[2:0] = 3'(state_reg);
      default: mapped = 1'b0;
    endcase
  end

  assign o_pslverr = req.psel && req.penable && !mapped;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg2_reg <= '{single: cfg2_rst[`DCS_CFG2_SINGLE],
                    cytime: cfg2_rst[`DCS_CFG2_CYTIME_HI:`DCS_CFG2_CYTIME_LO],
                    avg: cfg2_rst[`DCS_CFG2_AVG_HI:`DCS_CFG2_AVG_LO]};
      cfg3_reg <= '{bridge: bridge_t'(cfg3_rst[`DCS_CFG3_BRIDGE_HI:`DCS_CFG3_BRIDGE_LO]),
                    adjust: cfg3_rst[`DCS_CFG3_ADJ_HI:`DCS_CFG3_ADJ_LO],
                    stretch: cfg3_rst[`DCS_CFG3_STRETCH_HI:`DCS_CFG3_STRETCH_LO],
                    extra: cfg3_rst[`DCS_CFG3_EXTRA_HI:`DCS_CFG3_EXTRA_LO]};
      mask_reg <= `DCS_MASK_RST;
    end else if (wr_en) begin
      if (req.paddr == `DCS_ADDR_CFG2) begin
        cfg2_reg <= '{single: req.pwdata[`DCS_CFG2_SINGLE],
                      cytime: req.pwdata[`DCS_CFG2_CYTIME_HI:`DCS_CFG2_CYTIME_LO],
                      avg: req.pwdata[`DCS_CFG2_AVG_HI:`DCS_CFG2_AVG_LO]};
      end
      if (req.paddr == `DCS_ADDR_CFG3) begin
        cfg3_reg <= '{bridge: bridge_t'(req.pwdata[`DCS_CFG3_BRIDGE_HI:`DCS_CFG3_BRIDGE_LO]),
                      adjust: req.pwdata[`DCS_CFG3_ADJ_HI:`DCS_CFG3_ADJ_LO],
                      stretch: req.pwdata[`DCS_CFG3_STRETCH_HI:`DCS_CFG3_STRETCH_LO],
                      extra: req.pwdata[`DCS_CFG3_EXTRA_HI:`DCS_CFG3_EXTRA_LO]};
      end
      if (req.paddr == `DCS_ADDR_MASK) begin
        mask_reg <= req.pwdata[1:0];
      end
    end
  end

  // Run bit: single conversion clears it when the sequence ends
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_reg <= ctrl_rst[`DCS_CTRL_RUN];
    end else if (wr_en && (req.paddr == `DCS_ADDR_CTRL)) begin
      run_reg <= req.pwdata[`DCS_CTRL_RUN];
    end else if ((state_reg == ST_DONE) && cfg2_reg.single) begin
      run_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    status_next = status_reg;
    if (wr_en && (req.paddr == `DCS_ADDR_STATUS)) begin
      status_next = status_reg & ~req.pwdata[1:0];
    end
    status_next = status_next | status_set;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_reg <= 2'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign o_irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // Interval timing
  // ----------------------------------------------------------------
  logic stretched;
  logic fast_tick;
  logic itv_tick;
  logic itv_load;
  logic [9:0] itv_val;
  logic itv_expired;
  logic [2:0] cyc_reg;

  assign stretched = (cfg3_reg.stretch != 2'h0);
  assign itv_load = (state_reg == ST_FIRE);

  // fast step prescaler
  // First step is shortened by the fire cycle and the gap exit cycle
  dcs_interval_timer #(.W(8)) u_prescale (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_load(fast_tick || itv_load),
    .i_load_val(itv_load ? 8'(`DCS_FAST_FIRST_CYC) : 8'(`DCS_FAST_STEP_CYC)),
    .i_tick(1'b1),
    .o_expired(fast_tick)
  );

  assign itv_tick = stretched ? i_slow_tick : (fast_tick && !itv_load);

  always_comb begin
    itv_val = cfg2_reg.cytime;
    if (stretched && !cyc_reg[0]) begin
      itv_val = {8'h00, cfg3_reg.stretch};
    end
  end

  dcs_interval_timer #(.W(10)) u_interval (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_load(itv_load),
    .i_load_val(itv_val),
    .i_tick(itv_tick),
    .o_expired(itv_expired)
  );

  // ----------------------------------------------------------------
  // Sequence counters
  // ----------------------------------------------------------------
  logic [3:0] cps;
  logic [9:0] avg_eff;
  logic [9:0] sample_reg;
  logic [3:0] extra_reg;
  logic in_extra_reg;
  logic cycle_ok;
  logic sample_end;
  logic seq_last;

  // cycles per sample from bridge type
  always_comb begin
    unique case (cfg3_reg.bridge)
      BRIDGE_HALF: cps = `DCS_CPS_HALF;
      BRIDGE_QUATTRO: cps = `DCS_CPS_QUATTRO;
      default: cps = `DCS_CPS_FULL;
    endcase
  end

  assign avg_eff = (cfg2_reg.avg == 10'h000) ? 10'h001 : cfg2_reg.avg;
  assign cycle_ok = (state_reg == ST_MEAS) && i_meas_done;
  assign sample_end = ({1'b0, cyc_reg} == (cps - 4'h1));
  assign seq_last = in_extra_reg ? (extra_reg == (cfg3_reg.extra - 4'h1))
                  : (sample_end && (sample_reg == (avg_eff - 10'h001))
                     && (cfg3_reg.extra == 4'h0));

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cyc_reg <= 3'h0;
      sample_reg <= 10'h000;
      extra_reg <= 4'h0;
      in_extra_reg <= 1'b0;
    end else if (state_reg == ST_IDLE || state_reg == ST_DONE) begin
      cyc_reg <= 3'h0;
      sample_reg <= 10'h000;
      extra_reg <= 4'h0;
      in_extra_reg <= 1'b0;
    end else if (cycle_ok) begin
      if (in_extra_reg) begin
        extra_reg <= extra_reg + 4'h1;
      end else if (sample_end) begin
        cyc_reg <= 3'h0;
        sample_reg <= sample_reg + 10'h001;
        if (sample_reg == (avg_eff - 10'h001)) begin
          in_extra_reg <= 1'b1;
        end
      end else begin
        cyc_reg <= cyc_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (run_reg) state_reg <= ST_FIRE;
        ST_FIRE: state_reg <= ST_MEAS;
        ST_MEAS: if (i_meas_done) state_reg <= seq_last ? ST_DONE : ST_GAP;
        ST_GAP: if (itv_expired) state_reg <= run_reg ? ST_FIRE : ST_IDLE;
        ST_DONE: state_reg <= (run_reg && !cfg2_reg.single) ? ST_GAP : ST_IDLE;
      endcase
    end
  end

  assign o_discharge_start = (state_reg == ST_FIRE);
  assign o_seq_done = (state_reg == ST_DONE);

  // ----------------------------------------------------------------
  // Accumulation and result
  // ----------------------------------------------------------------
  logic signed [31:0] acc_reg;
  logic signed [31:0] acc_sat;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_reg <= 32'sh0000_0000;
    end else if (state_reg == ST_DONE) begin
      acc_reg <= 32'sh0000_0000;
    end else if (cycle_ok && !in_extra_reg) begin
      acc_reg <= cyc_reg[0] ? acc_reg - 32'(signed'(i_meas_value))
                            : acc_reg + 32'(signed'(i_meas_value));
    end
  end

  always_comb begin
    acc_sat = acc_reg;
    if (acc_reg > `DCS_RES_MAX) acc_sat = `DCS_RES_MAX;
    if (acc_reg < `DCS_RES_MIN) acc_sat = `DCS_RES_MIN;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      result_reg <= 24'h00_0000;
    end else if (state_reg == ST_DONE) begin
      result_reg <= acc_sat[23:0];
    end
  end

  assign o_bridge_result_word = result_reg;

  assign status_set[`DCS_ST_DONE] = (state_reg == ST_DONE);
  assign status_set[`DCS_ST_OVF] = (state_reg == ST_MEAS) && itv_expired
                                   && !i_meas_done && !stretched;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_FIRE_ONE_CYCLE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_discharge_start |=> !o_discharge_start && state_reg == ST_MEAS)
    else $error("discharge start not a single pulse");
  AST_GAP_HOLDS: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (state_reg == ST_GAP && !itv_expired) |=> !o_discharge_start)
    else $error("discharge started before interval elapsed");
  AST_FAST_STEP: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (fast_tick && !itv_load) |=> !fast_tick [*8])
    else $error("fast step tick too frequent");
  AST_PAIR_SPACING: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (itv_load && stretched && !cyc_reg[0]) |-> itv_val == {8'h00, cfg3_reg.stretch})
    else $error("pair spacing not from stretch setting");
  AST_STRETCH_WAIT: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (itv_load && stretched && cyc_reg[0]) |-> itv_val == cfg2_reg.cytime)
    else $error("stretched wait not from cycle field");
  AST_OVERFLOW: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (state_reg == ST_MEAS && itv_expired && !i_meas_done && !stretched)
    |=> status_reg[`DCS_ST_OVF])
    else $error("overflow not flagged");
  AST_CYC_RANGE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    {1'b0, cyc_reg} < cps)
    else $error("cycle index beyond bridge grouping");
  AST_SAMPLES: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_seq_done |-> sample_reg == avg_eff)
    else $error("sequence ended with wrong sample count");
  AST_EXTRAS: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_seq_done |-> extra_reg == cfg3_reg.extra)
    else $error("sequence ended with wrong extra count");
  AST_RESULT: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !o_seq_done |=> $stable(result_reg))
    else $error("result changed outside sequence end");
  AST_SATURATE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_seq_done && acc_reg > `DCS_RES_MAX |=> result_reg == 24'h7f_ffff)
    else $error("result not saturated high");
  AST_IRQ: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(status_reg[`DCS_ST_DONE]) && mask_reg[`DCS_ST_DONE] |-> o_irq)
    else $error("interrupt missing");
endmodule
`default_nettype wire

// *** discharge_cycle_sequencer_tb_top.sv ***
// Self-checking testbench of the discharge cycle sequencer
`timescale 1ns/100ps
`default_nettype none
`include "dcs_map.svh"
module discharge_cycle_sequencer_tb_top;
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, tick, mdone;
  logic dstart, sdone, irq, str_on, started, seq_pend;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] mval, res, va, vb, a, b;
  logic [15:0] pdly;
  logic [7:0] dis_cnt;
  logic [32:0] exp_q[$];
  logic [31:0] seq_q[$];
  int gap_q[$];
  int error_cnt, check_count, cyc, clks, ticks, tick_div, cps, avg;
  logic [1:0] codes[3] = '{2'h0, 2'h1, 2'h3};

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  dcs_sequencer dut_u (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_slow_tick(tick),
    .i_meas_done(mdone), .i_meas_value(mval), .o_discharge_start(dstart),
    .o_seq_done(sdone), .o_bridge_result_word(res), .o_irq(irq));

  dcs_front_end_model fe_u (.i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_start(dstart),
    .i_seq_done(sdone), .i_delay(pdly), .i_val_even(va), .i_val_odd(vb),
    .o_meas_done(mdone), .o_meas_value(mval));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 50) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] ad, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask

  task automatic irq_chk(input logic e);
    @(negedge ref_clk);
    chk({32'h0, irq}, {32'h0, e});
  endtask

  task automatic run_seq(input logic [1:0] br, input int cp, input int av, input int ext,
      input int cyt, input int stv, input int dly, input logic [23:0] ea,
      input logic [23:0] eb, input bit gaps);
    int n;
    longint s;
    logic [23:0] r;
    n = 0;
    s = longint'(cp * av / 2) * (longint'($signed(ea)) - longint'($signed(eb)));
    r = (s > 8388607) ? 24'h7fffff : (s < -8388608) ? 24'h800000 : 24'(s);
    seq_q.push_back({8'(cp * av + ext), r});
    if (gaps)
      for (int k = 0; k < cp * av + ext - 1; k++)
        gap_q.push_back(stv == 0 ? cyt * 250 : ((k % 2 == 0) ? stv : cyt));
    pdly <= 16'(dly);
    va <= ea;
    vb <= eb;
    str_on = (stv != 0);
    apb(1'b1, `DCS_ADDR_CFG3, {12'h0, 4'(ext), 2'h0, 2'(stv), 2'h0, 6'(2 * av), 2'h0, br});
    apb(1'b1, `DCS_ADDR_CFG2, {8'h0, 10'(av), 10'(cyt), 1'b0, 1'b1, 2'h0});
    apb(1'b1, `DCS_ADDR_CTRL, 32'h1);
    while (sdone !== 1'b1 && n < 40000) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 40000) error_cnt++;
    repeat (3) @(posedge ref_clk);
    rd(`DCS_ADDR_CTRL, 33'h0);
  endtask

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    tick_div = (tick_div == 39) ? 0 : tick_div + 1;
    tick <= (tick_div == 0);
    if (cyc > 90000) begin
      error_cnt++;
      conclude();
    end
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
    if (dstart === 1'b1) begin
      if (started && gap_q.size() > 0)
        chk(33'(str_on ? ticks : clks), 33'(gap_q.pop_front()));
      started = 1'b1;
      clks = 1;
      ticks = 0;
      dis_cnt = dis_cnt + 8'h01;
    end else begin
      clks++;
      if (tick) ticks++;
    end
    if (sdone === 1'b1) begin
      started = 1'b0;
      seq_pend = 1'b1;
    end else if (seq_pend) begin
      seq_pend = 1'b0;
      chk({1'b0, dis_cnt, res}, {1'b0, seq_q.pop_front()});
      dis_cnt = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, tick, started, seq_pend, str_on} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pdly = 16'h0003;
    {va, vb, dis_cnt} = '0;
    a = 24'($urandom(32'h829d9e3b));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`DCS_ADDR_CTRL, {1'b0, `DCS_CTRL_RST});
    rd(`DCS_ADDR_CFG2, {1'b0, `DCS_CFG2_RST});
    rd(`DCS_ADDR_CFG3, {1'b0, `DCS_CFG3_RST});
    rd(`DCS_ADDR_STATUS, 33'h0);
    rd(`DCS_ADDR_MASK, 33'h0);
    rd(`DCS_ADDR_RESULT, 33'h0);
    apb(1'b1, 12'h01c, 32'hffffffff);
    apb(1'b1, `DCS_ADDR_SEQ, 32'hffffffff);
    rd(12'h01c, {1'b1, 32'h0});
    rd(`DCS_ADDR_SEQ, 33'h0);
    apb(1'b1, `DCS_ADDR_MASK, 32'h1);
    // even counts and long enough interval
    for (int i = 0; i < 3; i++) begin
      cps = (i == 0) ? 2 : (i == 1) ? 4 : 8;
      avg = 2 * $urandom_range(1, 2);
      a = 24'($urandom_range(65535)) - 24'h008000;
      b = 24'($urandom_range(65535)) - 24'h008000;
      run_seq(codes[i], cps, avg, 1, 2, 0, 3, a, b, 1'b1);
      irq_chk(1'b1);
      rd(`DCS_ADDR_STATUS, 33'h1);
      apb(1'b1, `DCS_ADDR_STATUS, 32'h1);
      irq_chk(1'b0);
    end
    run_seq(2'h2, 4, 2, 0, 2, 0, 3, a, b, 1'b1);
    run_seq(2'h0, 2, 2, 0, 2, 0, 3, 24'h7fffff, 24'h800000, 1'b1);
    run_seq(2'h0, 2, 2, 0, 2, 0, 3, 24'h800000, 24'h7fffff, 1'b1);
    apb(1'b1, `DCS_ADDR_STATUS, 32'h3);
    apb(1'b1, `DCS_ADDR_MASK, 32'h2);
    run_seq(2'h0, 2, 2, 0, 1, 0, 400, a, b, 1'b0);
    rd(`DCS_ADDR_STATUS, 33'h3);
    irq_chk(1'b1);
    apb(1'b1, `DCS_ADDR_STATUS, 32'h2);
    irq_chk(1'b0);
    rd(`DCS_ADDR_STATUS, 33'h1);
    apb(1'b1, `DCS_ADDR_MASK, 32'h1);
    irq_chk(1'b1);
    apb(1'b1, `DCS_ADDR_STATUS, 32'h1);
    irq_chk(1'b0);
    run_seq(2'h0, 2, 2, 0, 3, 2, 5, a, b, 1'b1);
    run_seq(2'h1, 4, 2, 0, 2, 3, 5, b, a, 1'b1);
    rd(`DCS_ADDR_STATUS, 33'h1);
    conclude();
  end
endmodule
`default_nettype wire
